// ### core/can_irq_buf.sv
// Summary of operation
// - wake-up event raises wake interrupt only when enable bit 7 is set
// - status change flag raises error interrupt only when enable bit 6 set
// - rx sensitivity bits 5-4: none, bus-off, warning or bus-off, every change
// - rx state flags track receiver state, updated only while no status change pending
// - tx sensitivity bits 3-2: none, bus-off, warning or bus-off, every change
// - tx state flags track transmitter state, updated only while no status change pending
// - overrun event raises error interrupt only when enable bit 1 set
// - receive full raises receiver interrupt only when enable bit 0 set
// - receiver and transmitter share one state code, bus-off included
// - each transmit empty flag has its own enable bit gating its request
// - window bytes 0-3 identifier, 4-B data, C length, all read/write
// - timestamp bytes E and F are read-only
// - priority byte D exists only for transmit buffers
// - receive and transmit buffers share one 13-byte layout
// - buffer contents undefined after reset, priority bytes reset to zero
// - reserved buffer bits read undefined
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module can_irq_buf
	import can_irq_pkg::*;
#(
	parameter int NUM_RX_BUF = 1,
	parameter int NUM_TX_BUF = 3
) (
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic [5:0]             addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic [7:0]                  rdata,
	input  wire can_irq_pkg::can_event_type events,
	input  wire logic [NUM_TX_BUF-1:0]  tx_empty,
	input  wire logic                   rx_wr,
	input  wire logic [3:0]             rx_wr_ofs,
	input  wire logic [7:0]             rx_wr_data,
	input  wire logic [15:0]            stamp,
	input  wire logic                   stamp_wr,
	input  wire logic [1:0]             stamp_buf,
	output can_irq_pkg::can_irq_type    irq_req,
	output logic                        wake_function_en,
	output logic                        irq
);
	import can_irq_pkg::*;

	localparam int NBUF = NUM_RX_BUF + NUM_TX_BUF;

	logic [7:0]    rx_irq_en_q;
	logic [7:0]    tx_irq_en_q;
	logic [7:0]    control_q;
	logic [7:0]    mask_q;
	logic [3:0]    status_q;
	logic [1:0]    buf_sel_q;
	logic          wake_flag_q;
	logic          status_change_flag_q;
	logic          overrun_flag_q;
	logic          rx_full_flag_q;
	err_state_type rx_state_flags_q;
	err_state_type tx_state_flags_q;
	err_state_type rx_prev_q;
	err_state_type tx_prev_q;
	logic [7:0]    mem [NBUF][13];
	logic [7:0]    stamp_hi_mem [NBUF];
	logic [7:0]    stamp_lo_mem [NBUF];
	logic [7:0]    priority_q [NUM_TX_BUF];
	logic [7:0]    rdata_q;

	// does a change from a to b qualify at this sensitivity
	function automatic logic qualifies(input sens_type s, input err_state_type a,
		input err_state_type b);
		logic hit;
		hit = 1'b0;
		case (s)
			SENS_NONE:    hit = 1'b0;
			SENS_BUSOFF:  hit = (a == ST_BUSOFF) != (b == ST_BUSOFF);
			SENS_WARNING: hit = ((a == ST_BUSOFF) != (b == ST_BUSOFF))
				|| ((a == ST_WARNING) != (b == ST_WARNING));
			SENS_ALL:     hit = (a != b);
			default:      hit = 1'b0;
		endcase
		return hit;
	endfunction : qualifies

	// sticky bit: a set in the same cycle as a clear wins, so no event is lost
	function automatic logic sticky_next(input logic set, input logic held, input logic clr);
		return set || (held && !clr);
	endfunction : sticky_next

	wire sens_type rx_sens = sens_type'(rx_irq_en_q[POS_RX_SENS +: 2]);
	wire sens_type tx_sens = sens_type'(rx_irq_en_q[POS_TX_SENS +: 2]);
	wire wr_rx_flag = wr && (addr == ADDR_RX_FLAG);
	wire rd_status  = rd && (addr == ADDR_IRQ_STATUS);
	wire in_window  = (addr >= ADDR_WINDOW_BASE) && (addr <= ADDR_WINDOW_TOP);
	wire [3:0] ofs  = addr[3:0];
	wire win_wr     = wr && in_window;

	// receiver state change at the rx sensitivity, previous level against current rx state
	wire rx_change = qualifies(rx_sens, rx_prev_q, events.rx_state);
	wire tx_change = qualifies(tx_sens, tx_prev_q, events.tx_state);
	wire state_event = rx_change || tx_change;

	// write-one clear strobes of the flag register
	wire clr_wake    = wr_rx_flag && wdata[BIT_WAKE_FLAG];
	wire clr_status  = wr_rx_flag && wdata[BIT_STATUS_FLAG];
	wire clr_overrun = wr_rx_flag && wdata[BIT_OVERRUN_FLAG];
	wire clr_rx_full = wr_rx_flag && wdata[BIT_RX_FULL_FLAG];

	// flags: set wins over a write-one clear in the same cycle
	wire wake_flag_d          = sticky_next(events.wake, wake_flag_q, clr_wake);
	wire status_change_flag_d = sticky_next(state_event, status_change_flag_q, clr_status);
	wire overrun_flag_d       = sticky_next(events.overrun, overrun_flag_q, clr_overrun);
	wire rx_full_flag_d       = sticky_next(events.rx_full, rx_full_flag_q, clr_rx_full);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			wake_flag_q <= 1'b0;
		else
			wake_flag_q <= wake_flag_d;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			status_change_flag_q <= 1'b0;
		else
			status_change_flag_q <= status_change_flag_d;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			overrun_flag_q <= 1'b0;
		else
			overrun_flag_q <= overrun_flag_d;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rx_full_flag_q <= 1'b0;
		else
			rx_full_flag_q <= rx_full_flag_d;
	end

	// previous levels, for change detection one cycle later
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev_q <= ST_OK;
			tx_prev_q <= ST_OK;
		end else begin
			rx_prev_q <= events.rx_state;
			tx_prev_q <= events.tx_state;
		end
	end

	// state flags frozen while a status change is pending so software sees its cause
	wire state_flags_open = !status_change_flag_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rx_state_flags_q <= ST_OK;
		else if (state_flags_open)
			rx_state_flags_q <= events.rx_state;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			tx_state_flags_q <= ST_OK;
		else if (state_flags_open)
			tx_state_flags_q <= events.tx_state;
	end

	// register write decode
	wire wr_rx_irq_en  = wr && (addr == ADDR_RX_IRQ_EN);
	wire wr_tx_irq_en  = wr && (addr == ADDR_TX_IRQ_EN);
	wire wr_control    = wr && (addr == ADDR_CONTROL_0);
	wire wr_mask       = wr && (addr == ADDR_IRQ_MASK);
	wire wr_buf_select = wr && (addr == ADDR_BUF_SELECT);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rx_irq_en_q <= RST_RX_IRQ_EN;
		else if (wr_rx_irq_en)
			rx_irq_en_q <= wdata;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			tx_irq_en_q <= RST_TX_IRQ_EN;
		else if (wr_tx_irq_en)
			tx_irq_en_q <= wdata;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			control_q <= RST_CONTROL_0;
		else if (wr_control)
			control_q <= wdata;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			mask_q <= RST_MASK;
		else if (wr_mask)
			mask_q <= wdata;
	end

	// only the low two bits select; upper bits are dropped on purpose
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			buf_sel_q <= 2'b00;
		else if (wr_buf_select)
			buf_sel_q <= wdata[1:0];
	end

	// level requests, high while flag and enable both hold
	wire [NUM_TX_BUF-1:0] tx_gated = tx_empty & tx_irq_en_q[NUM_TX_BUF-1:0];
	assign irq_req.wake  = wake_flag_q && rx_irq_en_q[BIT_WAKE_IRQ_EN];
	assign irq_req.error = (status_change_flag_q && rx_irq_en_q[BIT_STATUS_IRQ_EN])
		|| (overrun_flag_q && rx_irq_en_q[BIT_OVERRUN_IRQ_EN]);
	assign irq_req.rx    = rx_full_flag_q && rx_irq_en_q[BIT_RX_FULL_IRQ_EN];
	assign irq_req.tx    = |tx_gated;
	assign wake_function_en = control_q[BIT_WAKE_FUNC_EN];

	// sticky summary, cleared by reading it; a new request wins over the read
	wire [3:0] req_vec     = {irq_req.wake, irq_req.error, irq_req.rx, irq_req.tx};
	wire [3:0] status_held = rd_status ? 4'h0 : status_q;
	wire [3:0] status_d    = req_vec | status_held;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			status_q <= 4'h0;
		else
			status_q <= status_d;
	end
	assign irq = |(status_q & mask_q[3:0]);

	// buffer ram: no reset, contents undefined until written
	wire [1:0] sel        = buf_sel_q;
	wire       win_ram_wr = win_wr && (ofs < OFS_PRIORITY);
	wire       eng_ram_wr = rx_wr && (rx_wr_ofs < OFS_PRIORITY);

	// engine write comes last, so a received byte beats software on the same cell
	always_ff @(posedge mclk) begin
		if (win_ram_wr)
			mem[sel][ofs] <= wdata;
		if (eng_ram_wr)
			mem[0][rx_wr_ofs] <= rx_wr_data;
	end

	always_ff @(posedge mclk) begin
		if (stamp_wr) begin
			stamp_hi_mem[stamp_buf] <= stamp[15:8];
			stamp_lo_mem[stamp_buf] <= stamp[7:0];
		end
	end

	// only transmit buffers hold a priority byte
	wire       sel_tx  = sel >= 2'(NUM_RX_BUF);
	wire [1:0] tx_idx  = sel - 2'(NUM_RX_BUF);
	wire       prio_wr = win_wr && (ofs == OFS_PRIORITY) && sel_tx;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_TX_BUF; i++)
				priority_q[i] <= RST_PRIORITY;
		end else if (prio_wr) begin
			priority_q[tx_idx] <= wdata;
		end
	end

	// read mux; stamp bytes have no window write path
	logic [7:0] win_rd;
	always_comb begin
		win_rd = 8'h00;
		if (ofs < OFS_PRIORITY)
			win_rd = mem[sel][ofs];
		else if (ofs == OFS_PRIORITY)
			win_rd = sel_tx ? priority_q[tx_idx] : 8'h00;
		else if (ofs == OFS_STAMP_HI)
			win_rd = stamp_hi_mem[sel];
		else
			win_rd = stamp_lo_mem[sel];
	end

	wire [7:0] flag_rd = {wake_flag_q, status_change_flag_q, rx_state_flags_q,
		tx_state_flags_q, overrun_flag_q, rx_full_flag_q};
	logic [7:0] reg_rd;
	always_comb begin
		reg_rd = 8'h00;
		case (addr)
			ADDR_RX_IRQ_EN:  reg_rd = rx_irq_en_q;
			ADDR_TX_IRQ_EN:  reg_rd = tx_irq_en_q;
			ADDR_RX_FLAG:    reg_rd = flag_rd;
			ADDR_IRQ_STATUS: reg_rd = {4'h0, status_q};
			ADDR_IRQ_MASK:   reg_rd = mask_q;
			ADDR_CONTROL_0:  reg_rd = control_q;
			ADDR_BUF_SELECT: reg_rd = {6'h00, buf_sel_q};
			default:         reg_rd = in_window ? win_rd : 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else if (rd)
			rdata_q <= reg_rd;
	end
	assign rdata = rdata_q;

endmodule : can_irq_buf

// ### core/can_irq_pkg.sv
package can_irq_pkg;

	// register indices on the plain port (byte-wide registers, one per address)
	localparam logic [5:0] ADDR_RX_IRQ_EN   = 6'h00;
	localparam logic [5:0] ADDR_TX_IRQ_EN   = 6'h01;
	localparam logic [5:0] ADDR_RX_FLAG     = 6'h02;
	localparam logic [5:0] ADDR_IRQ_STATUS  = 6'h03;
	localparam logic [5:0] ADDR_IRQ_MASK    = 6'h04;
	localparam logic [5:0] ADDR_CONTROL_0   = 6'h05;
	localparam logic [5:0] ADDR_BUF_SELECT  = 6'h06;
	localparam logic [5:0] ADDR_WINDOW_BASE = 6'h10;
	localparam logic [5:0] ADDR_WINDOW_TOP  = 6'h1F;

	// relative offsets within a message buffer window
	localparam logic [3:0] OFS_IDENT_0   = 4'h0;
	localparam logic [3:0] OFS_PAYLOAD_0 = 4'h4;
	localparam logic [3:0] OFS_LENGTH    = 4'hC;
	localparam logic [3:0] OFS_PRIORITY  = 4'hD;
	localparam logic [3:0] OFS_STAMP_HI  = 4'hE;
	localparam logic [3:0] OFS_STAMP_LO  = 4'hF;

	// receiver irq enable field positions
	localparam int BIT_WAKE_IRQ_EN    = 7;
	localparam int BIT_STATUS_IRQ_EN  = 6;
	localparam int POS_RX_SENS        = 4;
	localparam int POS_TX_SENS        = 2;
	localparam int BIT_OVERRUN_IRQ_EN = 1;
	localparam int BIT_RX_FULL_IRQ_EN = 0;

	// receiver flag register positions
	localparam int BIT_WAKE_FLAG    = 7;
	localparam int BIT_STATUS_FLAG  = 6;
	localparam int POS_RX_STATE     = 4;
	localparam int POS_TX_STATE     = 2;
	localparam int BIT_OVERRUN_FLAG = 1;
	localparam int BIT_RX_FULL_FLAG = 0;

	localparam int BIT_WAKE_FUNC_EN = 2;

	localparam logic [7:0] RST_RX_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_TX_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_MASK      = 8'h00;
	localparam logic [7:0] RST_CONTROL_0 = 8'h00;
	localparam logic [7:0] RST_PRIORITY  = 8'h00;

	typedef enum logic [1:0] {
		SENS_NONE    = 2'b00,
		SENS_BUSOFF  = 2'b01,
		SENS_WARNING = 2'b10,
		SENS_ALL     = 2'b11
	} sens_type;

	// error state code shared by receiver and transmitter
	typedef enum logic [1:0] {
		ST_OK      = 2'b00,
		ST_WARNING = 2'b01,
		ST_PASSIVE = 2'b10,
		ST_BUSOFF  = 2'b11
	} err_state_type;

	typedef struct packed {
		logic          wake;
		logic          overrun;
		logic          rx_full;
		err_state_type rx_state;
		err_state_type tx_state;
	} can_event_type;

	typedef struct packed {
		logic wake;
		logic error;
		logic rx;
		logic tx;
	} can_irq_type;

endpackage : can_irq_pkg

// ### testbench/can_irq_checker_assertions.sv
`timescale 1ns/1ps
module can_irq_checker
	import can_irq_pkg::*;
(
	input wire logic                       mclk,
	input wire logic                       rst_n,
	input wire logic [5:0]                 addr,
	input wire logic [7:0]                 wdata,
	input wire logic                       wr,
	input wire logic                       rd,
	input wire logic [7:0]                 rdata,
	input wire can_irq_pkg::can_event_type events,
	input wire can_irq_pkg::can_irq_type   irq_req,
	input wire logic                       irq
);
	logic [7:0] en_q;
	logic [7:0] mk_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 8'h00;
			mk_q <= 8'h00;
		end else if (wr) begin
			if (addr == ADDR_RX_IRQ_EN) en_q <= wdata;
			if (addr == ADDR_IRQ_MASK) mk_q <= wdata;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_wake_gate: assert property (events.wake |=> irq_req.wake == en_q[7])
		else $error("wake request disagrees with enable");
	a_wake_off: assert property (!en_q[7] |-> !irq_req.wake)
		else $error("wake request while disabled");
	a_full_gate: assert property (events.rx_full |=> irq_req.rx == en_q[0])
		else $error("receive request disagrees with enable");
	a_full_off: assert property (!en_q[0] |-> !irq_req.rx)
		else $error("receive request while disabled");
	a_overrun_err: assert property (events.overrun && en_q[1] |=> irq_req.error)
		else $error("overrun gave no error request");
	a_error_off: assert property (!en_q[6] && !en_q[1] |-> !irq_req.error)
		else $error("error request while disabled");
	a_req_level: assert property (irq_req.wake && !wr |=> irq_req.wake)
		else $error("wake request dropped without clear");
	a_irq_mask: assert property (irq_req.wake && mk_q[3] && !wr |=> irq)
		else $error("unmasked status gave no interrupt");
	a_irq_quiet: assert property (mk_q == 8'h00 |-> !irq)
		else $error("interrupt with all masked");
	a_rdata_hold: assert property (!$past(rd) |-> $stable(rdata))
		else $error("read data moved without read");
endmodule : can_irq_checker
bind can_irq_buf can_irq_checker can_irq_checker_i (.mclk(mclk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .events(events), .irq_req(irq_req), .irq(irq));

// ### testbench/can_irq_enable_and_msg_buffer_tb_top.sv
`timescale 1ns/1ps
module can_irq_enable_and_msg_buffer_tb_top;
	import can_irq_pkg::*;
	logic mclk, rst_n, wr, rd, stamp_wr, wake_function_en, irq, rx_wr;
	logic [5:0] addr;
	logic [7:0] wdata, rdata, v, rx_wr_data, mem [0:3][0:13];
	logic [2:0] tx_empty;
	logic [3:0] rx_wr_ofs;
	logic [15:0] stamp, sv;
	logic [1:0] stamp_buf;
	can_event_type events;
	can_irq_type irq_req;
	err_state_type cur, shown, seq [0:5];
	bit flag;
	int n_fail, checks;
	can_irq_buf can_irq_buf_i (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .events(events), .tx_empty(tx_empty), .rx_wr(rx_wr),
		.rx_wr_ofs(rx_wr_ofs), .rx_wr_data(rx_wr_data), .stamp(stamp), .stamp_wr(stamp_wr),
		.stamp_buf(stamp_buf), .irq_req(irq_req), .wake_function_en(wake_function_en), .irq(irq));
	can_node_model can_node_model_i (.mclk(mclk), .events(events), .tx_empty(tx_empty),
		.stamp(stamp), .stamp_wr(stamp_wr), .stamp_buf(stamp_buf));
	initial begin
		{mclk, rst_n, wr, rd, addr, wdata, rx_wr, rx_wr_ofs, rx_wr_data} = '0;
		n_fail = 0;
		checks = 0;
	end
	always #12.5 mclk = ~mclk;
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] exp);
		@(posedge mclk);
		{rd, addr} <= {1'b1, a};
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(nm, rdata, exp);
	endtask : rchk
	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask : settle
	function automatic bit hit(input logic [1:0] s, input err_state_type a, input err_state_type b);
		bit bo = (a == ST_BUSOFF) || (b == ST_BUSOFF);
		bit wn = (a == ST_WARNING) || (b == ST_WARNING);
		case (s)
			2'b00: return 1'b0;
			2'b01: return bo;
			2'b10: return bo || wn;
			default: return a != b;
		endcase
	endfunction : hit
	task automatic stop_test();
		if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	initial begin
		#2000000;
		n_fail++;
		stop_test();
	end
	initial begin
		seq = '{ST_WARNING, ST_OK, ST_PASSIVE, ST_OK, ST_BUSOFF, ST_OK};
		void'($urandom(32'h7f83));
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		for (int a = 0; a < 6; a++) rchk("reset reg", 6'(a), 8'h00);
		// all buffers written before any read, so aliasing shows
		for (int b = 0; b < 4; b++) begin
			wr_reg(ADDR_BUF_SELECT, 8'(b));
			for (int o = 0; o < (b == 0 ? 13 : 14); o++) begin
				mem[b][o] = 8'($urandom);
				wr_reg(ADDR_WINDOW_BASE + 6'(o), mem[b][o]);
			end
		end
		for (int b = 0; b < 4; b++) begin
			wr_reg(ADDR_BUF_SELECT, 8'(b));
			for (int o = 0; o < (b == 0 ? 13 : 14); o++)
				rchk("buffer byte", ADDR_WINDOW_BASE + 6'(o), mem[b][o]);
		end
		sv = 16'($urandom);
		can_node_model_i.put_stamp(2'h2, sv);
		wr_reg(ADDR_BUF_SELECT, 8'h02);
		wr_reg(ADDR_WINDOW_BASE + 6'hE, ~sv[15:8]);
		wr_reg(ADDR_WINDOW_BASE + 6'hF, ~sv[7:0]);
		rchk("stamp high", ADDR_WINDOW_BASE + 6'hE, sv[15:8]);
		rchk("stamp low", ADDR_WINDOW_BASE + 6'hF, sv[7:0]);
		rchk("unmapped", 6'h3F, 8'h00);
		// receive engine path into buffer 0
		v = 8'($urandom);
		wr_reg(ADDR_BUF_SELECT, 8'h00);
		@(posedge mclk);
		{rx_wr, rx_wr_ofs, rx_wr_data} <= {1'b1, OFS_LENGTH, v};
		@(posedge mclk);
		rx_wr <= 1'b0;
		rchk("engine byte", ADDR_WINDOW_BASE + 6'(OFS_LENGTH), v);
		wr_reg(ADDR_IRQ_MASK, 8'h0E);
		for (int e = 0; e < 2; e++) begin
			wr_reg(ADDR_RX_IRQ_EN, e ? 8'h83 : 8'h00);
			can_node_model_i.pulse(3'b111);
			settle();
			chk("wake req", {7'h00, irq_req.wake}, 8'(e));
			chk("error req", {7'h00, irq_req.error}, 8'(e));
			chk("rx req", {7'h00, irq_req.rx}, 8'(e));
			chk("irq", {7'h00, irq}, 8'(e));
			rchk("status", ADDR_IRQ_STATUS, e ? 8'h0E : 8'h00);
			wr_reg(ADDR_RX_FLAG, 8'h83);
			rchk("status clear", ADDR_IRQ_STATUS, e ? 8'h0E : 8'h00);
			rchk("status empty", ADDR_IRQ_STATUS, 8'h00);
		end
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		for (int sd = 0; sd < 2; sd++) begin
			for (int s = 0; s < 4; s++) begin
				wr_reg(ADDR_RX_IRQ_EN, 8'(s << (sd ? POS_TX_SENS : POS_RX_SENS)) | 8'(s % 2 << 6));
				cur = ST_OK;
				shown = ST_OK;
				flag = 1'b0;
				for (int k = 0; k < 6; k++) begin
					can_node_model_i.set_state(sd ? ST_OK : seq[k], sd ? seq[k] : ST_OK);
					if (!flag) begin
						flag = hit(2'(s), cur, seq[k]);
						shown = seq[k];
					end
					cur = seq[k];
					settle();
					v = {1'b0, flag, sd ? {2'h0, shown} : {shown, 2'h0}, 2'h0};
					rchk("state flags", ADDR_RX_FLAG, v);
					chk("status req", {7'h00, irq_req.error}, {7'h00, flag & s[0]});
					if (k % 2 == 1) begin
						wr_reg(ADDR_RX_FLAG, 8'h40);
						shown = cur;
						flag = 1'b0;
					end
				end
			end
		end
		wr_reg(ADDR_TX_IRQ_EN, 8'h00);
		can_node_model_i.set_empty(3'h7);
		settle();
		chk("tx req off", {7'h00, irq_req.tx}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr_reg(ADDR_TX_IRQ_EN, 8'(1 << i));
			can_node_model_i.set_empty(3'(1 << i));
			settle();
			chk("tx req own", {7'h00, irq_req.tx}, 8'h01);
			can_node_model_i.set_empty(~3'(1 << i));
			settle();
			chk("tx req other", {7'h00, irq_req.tx}, 8'h00);
		end
		wr_reg(ADDR_CONTROL_0, 8'h04);
		wr_reg(ADDR_RX_IRQ_EN, 8'h80);
		settle();
		chk("wake function", {7'h00, wake_function_en}, 8'h01);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		for (int b = 1; b < 4; b++) begin
			wr_reg(ADDR_BUF_SELECT, 8'(b));
			rchk("priority reset", ADDR_WINDOW_BASE + 6'(OFS_PRIORITY), 8'h00);
		end
		stop_test();
	end
endmodule : can_irq_enable_and_msg_buffer_tb_top

// ### testbench/can_node_model.sv
`timescale 1ns/1ps
module can_node_model
	import can_irq_pkg::*;
#(
	parameter int NUM_TX_BUF = 3
) (
	input  wire logic                   mclk,
	output can_irq_pkg::can_event_type  events,
	output logic [NUM_TX_BUF-1:0]       tx_empty,
	output logic [15:0]                 stamp,
	output logic                        stamp_wr,
	output logic [1:0]                  stamp_buf
);
	initial begin
		events = '0;
		tx_empty = '0;
		stamp = 16'h0000;
		stamp_wr = 1'b0;
		stamp_buf = 2'h0;
	end
	// k is {wake, overrun, rx_full}, one cycle each
	task automatic pulse(input logic [2:0] k);
		@(posedge mclk);
		{events.wake, events.overrun, events.rx_full} <= k;
		@(posedge mclk);
		{events.wake, events.overrun, events.rx_full} <= 3'h0;
	endtask : pulse
	task automatic set_state(input err_state_type r, input err_state_type t);
		@(posedge mclk);
		events.rx_state <= r;
		events.tx_state <= t;
	endtask : set_state
	task automatic set_empty(input logic [NUM_TX_BUF-1:0] v);
		@(posedge mclk);
		tx_empty <= v;
	endtask : set_empty
	// value inverted after the strobe so a stale bus never looks valid
	task automatic put_stamp(input logic [1:0] b, input logic [15:0] v);
		@(posedge mclk);
		stamp_wr <= 1'b1;
		stamp <= v;
		stamp_buf <= b;
		@(posedge mclk);
		stamp_wr <= 1'b0;
		stamp <= ~v;
	endtask : put_stamp
endmodule : can_node_model
